// ---- hdl/serial_port.sv ----
// Asynchronous serial transmitter and receiver with its registers.
// Assumes a CPU register port on the shared clock and a far serial port.
`timescale 1ns/1ps
module serial_port #(
  parameter int OSC_HZ      = serial_port_pkg::CLK_HZ,
  parameter bit SERIAL_PINS = 1'b1,
  parameter int FIFO_DEPTH  = serial_port_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic       ref_clk_in,
  input  wire logic       rstn_in,
  // CPU register port
  input  wire logic [5:0] reg_addr_in,
  input  wire logic       reg_wr_in,
  input  wire logic       reg_rd_in,
  input  wire logic [7:0] reg_wdata_in,
  output logic      [7:0] reg_rdata_out,
  // Interrupt requests
  output logic            rx_irq_out,
  output logic            tx_irq_out,
  // Serial pins
  output logic            txd_out,
  input  wire logic       rxd_in,
  // General purpose use of the pins
  input  wire logic       port_bit_four_in,
  output logic            port_bit_five_out
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  localparam int DB = serial_port_pkg::DATA_BITS;
  logic [7:0]  command;              // Enables and modes
  logic [15:0] prescaler;            // Raw divider
  logic [15:0] baud_sel;             // Standard rate index
  logic [4:0]  flags;                // Sticky status bits
  logic [7:0]  next_command;
  logic [15:0] next_prescaler;
  logic [15:0] next_baud_sel;
  logic [4:0]  next_flags;
  logic [7:0]  next_rdata;
  logic        next_rx_irq;
  logic        next_tx_irq;
  logic [15:0] bit_cycles;           // Clocks per bit
  serial_port_pkg::tx_state_t tx_state;       // Transmit sequencer
  serial_port_pkg::tx_state_t next_tx_state;
  logic [15:0] tx_cnt;               // Bit timer
  logic [15:0] next_tx_cnt;
  logic [2:0]  tx_idx;               // Data bit index
  logic [2:0]  next_tx_idx;
  logic [7:0]  tx_shift;             // Byte being sent
  logic [7:0]  next_tx_shift;
  logic        tx_par;               // Running parity
  logic        next_tx_par;
  logic        tx_line;              // Line level
  logic        next_tx_line;
  logic        tx_done;              // Stop bit ended
  serial_port_pkg::rx_state_t rx_state;       // Receive sequencer
  serial_port_pkg::rx_state_t next_rx_state;
  logic [15:0] rx_cnt;
  logic [15:0] next_rx_cnt;
  logic [2:0]  rx_idx;
  logic [2:0]  next_rx_idx;
  logic [7:0]  rx_shift;
  logic [7:0]  next_rx_shift;
  logic        rx_par;
  logic        next_rx_par;
  logic        rx_line;              // Line seen by receiver
  logic        rx_done;              // Byte complete
  logic        rx_frame_err;
  logic        rx_par_err;
  logic        next_pin_five;
  logic        wr_data;              // Write to data register
  logic        rd_data;              // Read of data register
  logic        wr_status;            // Clear write to status

  byte_stream_if #(.WIDTH(DB)) rx_stream ();  // Receiver to buffer link

  // ----------------------------------------------------------------
  // Rate selection and receive buffer
  // ----------------------------------------------------------------
  bit_rate_select #(
    .OSC_HZ         (OSC_HZ)
  ) u_rate (
    .ref_clk_in     (ref_clk_in),
    .rstn_in        (rstn_in),
    .auto_cal_in    (command[serial_port_pkg::CMD_AUTO_CAL]),
    .baud_sel_in    (baud_sel),
    .prescaler_in   (prescaler),
    .bit_cycles_out (bit_cycles)
  );

  byte_fifo #(
    .WIDTH      (DB),
    .DEPTH      (FIFO_DEPTH)
  ) u_fifo (
    .ref_clk_in (ref_clk_in),
    .rstn_in    (rstn_in),
    .port       (rx_stream.buffer_side)
  );

  // Pin routing chosen at build time
  always_comb begin
    rx_line       = SERIAL_PINS ? rxd_in : 1'b1;
    next_pin_five = SERIAL_PINS ? 1'b0 : rxd_in;
    wr_data       = reg_wr_in && reg_addr_in == serial_port_pkg::OFS_DATA;
    rd_data       = reg_rd_in && reg_addr_in == serial_port_pkg::OFS_DATA;
    wr_status     = reg_wr_in && reg_addr_in == serial_port_pkg::OFS_STATUS;
  end

  // ----------------------------------------------------------------
  // Transmitter
  // ----------------------------------------------------------------
  // Next state of the transmit sequencer
  always_comb begin
    next_tx_state = tx_state;
    next_tx_cnt   = tx_cnt;
    next_tx_idx   = tx_idx;
    next_tx_shift = tx_shift;
    next_tx_par   = tx_par;
    next_tx_line  = tx_line;
    tx_done       = 1'b0;
    case (tx_state)
      serial_port_pkg::TX_IDLE: begin
        next_tx_line = 1'b1;
        if (wr_data) begin                         // Writes while busy are dropped
          next_tx_state = serial_port_pkg::TX_START;
          next_tx_shift = reg_wdata_in;
          next_tx_par   = command[serial_port_pkg::CMD_PAR_ODD];
          next_tx_cnt   = bit_cycles - 16'h0001;
          next_tx_line  = 1'b0;
        end
      end
      serial_port_pkg::TX_START, serial_port_pkg::TX_DATA, serial_port_pkg::TX_PARITY, serial_port_pkg::TX_STOP: begin
        if (tx_cnt != 16'h0000) begin
          next_tx_cnt = tx_cnt - 16'h0001;
        end else begin
          next_tx_cnt = bit_cycles - 16'h0001;
          case (tx_state)
            serial_port_pkg::TX_START: begin
              next_tx_state = serial_port_pkg::TX_DATA;
              next_tx_idx   = 3'h0;
              next_tx_line  = tx_shift[0];
            end
            serial_port_pkg::TX_DATA: begin
              next_tx_par   = tx_par ^ tx_shift[0];
              next_tx_shift = {1'b0, tx_shift[7:1]};
              next_tx_idx   = tx_idx + 3'h1;
              if (tx_idx != 3'(DB - 1)) begin
                next_tx_line = tx_shift[1];
              end else if (command[serial_port_pkg::CMD_PAR_EN]) begin
                next_tx_state = serial_port_pkg::TX_PARITY;
                next_tx_line  = tx_par ^ tx_shift[0];
              end else begin
                next_tx_state = serial_port_pkg::TX_STOP;
                next_tx_line  = 1'b1;
              end
            end
            serial_port_pkg::TX_PARITY: begin
              next_tx_state = serial_port_pkg::TX_STOP;
              next_tx_line  = 1'b1;
            end
            default: begin
              next_tx_state = serial_port_pkg::TX_IDLE;
              tx_done       = 1'b1;
            end
          endcase
        end
      end
      default: begin
        next_tx_state = serial_port_pkg::TX_IDLE;
        next_tx_line  = 1'b1;
      end
    endcase
  end

  // Transmit registers
  always_ff @(posedge ref_clk_in) begin
    if (!rstn_in) begin
      tx_state <= serial_port_pkg::TX_IDLE;
      tx_cnt   <= 16'h0000;
      tx_idx   <= 3'h0;
      tx_shift <= 8'h00;
      tx_par   <= 1'b0;
      tx_line  <= 1'b1;
    end else begin
      tx_state <= next_tx_state;
      tx_cnt   <= next_tx_cnt;
      tx_idx   <= next_tx_idx;
      tx_shift <= next_tx_shift;
      tx_par   <= next_tx_par;
      tx_line  <= next_tx_line;
    end
  end

  // ----------------------------------------------------------------
  // Receiver
  // ----------------------------------------------------------------
  // Next state of the receive sequencer, sampling mid-bit
  always_comb begin
    next_rx_state = rx_state;
    next_rx_cnt   = rx_cnt;
    next_rx_idx   = rx_idx;
    next_rx_shift = rx_shift;
    next_rx_par   = rx_par;
    rx_done       = 1'b0;
    rx_frame_err  = 1'b0;
    rx_par_err    = 1'b0;
    case (rx_state)
      serial_port_pkg::RX_IDLE: begin
        if (!rx_line) begin
          next_rx_state = serial_port_pkg::RX_START;
          next_rx_cnt   = {1'b0, bit_cycles[15:1]};
        end
      end
      serial_port_pkg::RX_START, serial_port_pkg::RX_DATA, serial_port_pkg::RX_PARITY, serial_port_pkg::RX_STOP: begin
        if (rx_cnt != 16'h0000) begin
          next_rx_cnt = rx_cnt - 16'h0001;
        end else begin
          next_rx_cnt = bit_cycles - 16'h0001;
          case (rx_state)
            serial_port_pkg::RX_START: begin
              next_rx_idx = 3'h0;
              next_rx_par = command[serial_port_pkg::CMD_PAR_ODD];
              next_rx_state = rx_line ? serial_port_pkg::RX_IDLE : serial_port_pkg::RX_DATA;  // Glitch rejected
            end
            serial_port_pkg::RX_DATA: begin
              next_rx_shift = {rx_line, rx_shift[7:1]};
              next_rx_par   = rx_par ^ rx_line;
              next_rx_idx   = rx_idx + 3'h1;
              if (rx_idx == 3'(DB - 1)) begin
                next_rx_state = command[serial_port_pkg::CMD_PAR_EN] ? serial_port_pkg::RX_PARITY
                                                                     : serial_port_pkg::RX_STOP;
              end
            end
            serial_port_pkg::RX_PARITY: begin
              next_rx_par   = rx_par ^ rx_line;
              next_rx_state = serial_port_pkg::RX_STOP;
            end
            default: begin
              next_rx_state = serial_port_pkg::RX_IDLE;
              rx_done       = 1'b1;
              rx_frame_err  = !rx_line;
              rx_par_err    = command[serial_port_pkg::CMD_PAR_EN] & rx_par;
            end
          endcase
        end
      end
      default: begin
        next_rx_state = serial_port_pkg::RX_IDLE;
      end
    endcase
  end
  // Completed byte offered to the buffer
  always_comb begin
    rx_stream.in_valid  = rx_done;
    rx_stream.in_data   = rx_shift;
    rx_stream.out_ready = rd_data;
  end
  // Receive registers
  always_ff @(posedge ref_clk_in) begin
    if (!rstn_in) begin
      rx_state <= serial_port_pkg::RX_IDLE;
      rx_cnt   <= 16'h0000;
      rx_idx   <= 3'h0;
      rx_shift <= 8'h00;
      rx_par   <= 1'b0;
    end else begin
      rx_state <= next_rx_state;
      rx_cnt   <= next_rx_cnt;
      rx_idx   <= next_rx_idx;
      rx_shift <= next_rx_shift;
      rx_par   <= next_rx_par;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // Register writes, sticky flags and read data
  always_comb begin
    next_command   = command;
    next_prescaler = prescaler;
    next_baud_sel  = baud_sel;
    next_flags     = flags;
    next_rdata     = 8'h00;
    if (reg_wr_in) begin
      case (reg_addr_in)
        serial_port_pkg::OFS_COMMAND:  next_command          = reg_wdata_in;
        serial_port_pkg::OFS_PRESC_LO: next_prescaler[7:0]   = reg_wdata_in;
        serial_port_pkg::OFS_PRESC_HI: next_prescaler[15:8]  = reg_wdata_in;
        serial_port_pkg::OFS_BAUD_LO:  next_baud_sel[7:0]    = reg_wdata_in;
        serial_port_pkg::OFS_BAUD_HI:  next_baud_sel[15:8]   = reg_wdata_in;
        default: ;
      endcase
    end
    // Ones written to the status register clear flags
    if (wr_status) begin
      next_flags = flags & ~reg_wdata_in[4:0];
    end
    // Hardware events win over a clear in the same cycle
    next_flags[serial_port_pkg::STAT_RX_INT]   = next_flags[serial_port_pkg::STAT_RX_INT]
                                                 | (rx_done & rx_stream.in_ready);
    next_flags[serial_port_pkg::STAT_TX_INT]   = next_flags[serial_port_pkg::STAT_TX_INT] | tx_done;
    next_flags[serial_port_pkg::STAT_FRAME]    = next_flags[serial_port_pkg::STAT_FRAME]
                                                 | (rx_done & rx_frame_err);
    next_flags[serial_port_pkg::STAT_OVERRUN]  = next_flags[serial_port_pkg::STAT_OVERRUN]
                                                 | (rx_done & !rx_stream.in_ready);
    next_flags[serial_port_pkg::STAT_PARITY]   = next_flags[serial_port_pkg::STAT_PARITY]
                                                 | (rx_done & rx_par_err);
    if (reg_rd_in) begin
      case (reg_addr_in)
        serial_port_pkg::OFS_COMMAND:  next_rdata = command;
        serial_port_pkg::OFS_STATUS:   next_rdata = {1'b0, tx_state != serial_port_pkg::TX_IDLE,
                                                     rx_stream.out_valid, flags};
        serial_port_pkg::OFS_DATA:     next_rdata = rx_stream.out_data;
        serial_port_pkg::OFS_PRESC_LO: next_rdata = prescaler[7:0];
        serial_port_pkg::OFS_PRESC_HI: next_rdata = prescaler[15:8];
        serial_port_pkg::OFS_BAUD_LO:  next_rdata = baud_sel[7:0];
        serial_port_pkg::OFS_BAUD_HI:  next_rdata = baud_sel[15:8];
        default:                       next_rdata = 8'h00;
      endcase
    end
    // Requests follow flag and enable
    next_rx_irq = next_flags[serial_port_pkg::STAT_RX_INT] & next_command[serial_port_pkg::CMD_RX_IE];
    next_tx_irq = next_flags[serial_port_pkg::STAT_TX_INT] & next_command[serial_port_pkg::CMD_TX_IE];
  end

  // Register state and output flops
  always_ff @(posedge ref_clk_in) begin
    if (!rstn_in) begin
      command           <= serial_port_pkg::COMMAND_RESET;
      prescaler         <= serial_port_pkg::PRESC_RESET;
      baud_sel          <= serial_port_pkg::BAUD_RESET;
      flags             <= 5'h00;
      reg_rdata_out     <= 8'h00;
      rx_irq_out        <= 1'b0;
      tx_irq_out        <= 1'b0;
      txd_out           <= 1'b1;
      port_bit_five_out <= 1'b0;
    end else begin
      command           <= next_command;
      prescaler         <= next_prescaler;
      baud_sel          <= next_baud_sel;
      flags             <= next_flags;
      reg_rdata_out     <= next_rdata;
      rx_irq_out        <= next_rx_irq;
      tx_irq_out        <= next_tx_irq;
      txd_out           <= SERIAL_PINS ? tx_line : port_bit_four_in;
      port_bit_five_out <= next_pin_five;
    end
  end

endmodule : serial_port

// ---- common/serial_port_pkg.sv ----
// Constants, register map and state codes for the serial port block.
// Assumes one 10 MHz clock that is also the bit-clock source.
package serial_port_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [5:0] OFS_COMMAND  = 6'h29;  // serial_command
  localparam logic [5:0] OFS_STATUS   = 6'h2A;  // serial_command_status
  localparam logic [5:0] OFS_DATA     = 6'h2B;  // transmit / receive data
  localparam logic [5:0] OFS_PRESC_LO = 6'h2C;  // serial_prescaler_low
  localparam logic [5:0] OFS_PRESC_HI = 6'h2D;  // serial_prescaler_high
  localparam logic [5:0] OFS_BAUD_LO  = 6'h2E;  // baud_select_low
  localparam logic [5:0] OFS_BAUD_HI  = 6'h2F;  // baud_select_high

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CMD_TX_IE     = 0;  // Transmit interrupt enable
  localparam int CMD_RX_IE     = 1;  // Receive interrupt enable
  localparam int CMD_PAR_EN    = 2;  // Parity check enable
  localparam int CMD_PAR_ODD   = 3;  // Odd parity when set
  localparam int CMD_AUTO_CAL  = 4;  // Calibrated standard rate
  localparam int STAT_RX_INT   = 0;  // Byte received
  localparam int STAT_TX_INT   = 1;  // Byte sent
  localparam int STAT_FRAME    = 2;  // Stop bit was low
  localparam int STAT_OVERRUN  = 3;  // Byte lost, buffer full
  localparam int STAT_PARITY   = 4;  // Parity mismatch
  localparam int STAT_RX_AVAIL = 5;  // Buffer holds data
  localparam int STAT_TX_BUSY  = 6;  // Transmitter active

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0]  COMMAND_RESET = 8'h00;
  localparam logic [15:0] PRESC_RESET   = 16'h0056;
  localparam logic [15:0] BAUD_RESET    = 16'h0000;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100;                      // Clock period
  localparam int CLK_HZ        = 1000000000 / CLK_PERIOD_NS;
  localparam int MAX_BPS       = 115200;                   // Fastest rate
  localparam int MIN_BPS       = 1200;                     // Slowest rate
  localparam int MIN_OSC_RATIO = 20;                       // Osc / bit rate
  localparam int NUM_RATES     = 10;                       // Table entries
  localparam int DATA_BITS     = 8;
  localparam int FIFO_DEPTH    = 8;

  // Standard rates selectable in calibrated mode
  function automatic int rate_of(input int idx);
    case (idx)
      0:       return 1200;
      1:       return 2400;
      2:       return 4800;
      3:       return 9600;
      4:       return 19200;
      5:       return 38400;
      6:       return 51200;
      7:       return 57600;
      8:       return 102400;
      default: return MAX_BPS;
    endcase
  endfunction : rate_of

  // ----------------------------------------------------------------
  // State codes
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    TX_IDLE   = 5'b00001,
    TX_START  = 5'b00010,
    TX_DATA   = 5'b00100,
    TX_PARITY = 5'b01000,
    TX_STOP   = 5'b10000
  } tx_state_t;

  typedef enum logic [4:0] {
    RX_IDLE   = 5'b00001,
    RX_START  = 5'b00010,
    RX_DATA   = 5'b00100,
    RX_PARITY = 5'b01000,
    RX_STOP   = 5'b10000
  } rx_state_t;

endpackage : serial_port_pkg

// ---- common/byte_stream_if.sv ----
// Valid/ready byte stream between the receiver and its buffer.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface byte_stream_if #(
  parameter int WIDTH = 8
);
  logic             in_valid;   // Producer offers a word
  logic             in_ready;   // Buffer can take it
  logic [WIDTH-1:0] in_data;    // Word offered
  logic             out_valid;  // Buffer holds a word
  logic             out_ready;  // Consumer takes it
  logic [WIDTH-1:0] out_data;   // Oldest word

  modport buffer_side (input in_valid, in_data, out_ready, output in_ready, out_valid, out_data);
  modport user_side (output in_valid, in_data, out_ready, input in_ready, out_valid, out_data);
endinterface : byte_stream_if

// ---- hdl/byte_fifo.sv ----
// Small first-in first-out buffer for received bytes.
// Assumes a synchronous active-low reset on the shared clock.
`timescale 1ns/1ps
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic ref_clk_in,
  input  wire logic rstn_in,
  // Stream
  byte_stream_if.buffer_side port
);

  localparam int AW = $clog2(DEPTH);

  // Refuse shapes the pointers cannot serve
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_check
    $error("byte_fifo depth must be a power of two of at least 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];   // Storage
  logic [AW:0]      wr_ptr;        // Write pointer with wrap bit
  logic [AW:0]      rd_ptr;        // Read pointer with wrap bit
  logic [AW:0]      next_wr_ptr;
  logic [AW:0]      next_rd_ptr;
  logic             push;
  logic             pop;

  // Full and empty from the wrap bits
  always_comb begin
    port.in_ready  = (wr_ptr ^ rd_ptr) != {1'b1, {AW{1'b0}}};
    port.out_valid = wr_ptr != rd_ptr;
    port.out_data  = mem[rd_ptr[AW-1:0]];
    push           = port.in_valid & port.in_ready;
    pop            = port.out_valid & port.out_ready;
    next_wr_ptr    = wr_ptr + (AW+1)'(push);
    next_rd_ptr    = rd_ptr + (AW+1)'(pop);
  end

  // Pointers and storage
  always_ff @(posedge ref_clk_in) begin
    if (!rstn_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
    end
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= port.in_data;
    end
  end

endmodule : byte_fifo

// ---- hdl/bit_rate_select.sv ----
// Chooses the clocks-per-bit figure for the serial port.
// Assumes the block clock is the oscillator the rates derive from.
`timescale 1ns/1ps
module bit_rate_select #(
  parameter int OSC_HZ = serial_port_pkg::CLK_HZ
) (
  // Clock and reset
  input  wire logic        ref_clk_in,
  input  wire logic        rstn_in,
  // Settings
  input  wire logic        auto_cal_in,
  input  wire logic [15:0] baud_sel_in,
  input  wire logic [15:0] prescaler_in,
  // Result
  output logic      [15:0] bit_cycles_out
);

  // Oscillator must run twenty times the fastest rate
  if (OSC_HZ < serial_port_pkg::MAX_BPS * serial_port_pkg::MIN_OSC_RATIO
      || OSC_HZ / serial_port_pkg::MIN_BPS > 65535) begin : g_check
    $error("bit_rate_select oscillator rate out of range");
  end

  logic [15:0] table_cycles [serial_port_pkg::NUM_RATES];  // Cycles per standard rate
  logic [15:0] next_bit_cycles;

  // Calibrated figures fixed from the known oscillator rate
  for (genvar i = 0; i < serial_port_pkg::NUM_RATES; i++) begin : g_rate
    assign table_cycles[i] = 16'((OSC_HZ + serial_port_pkg::rate_of(i) / 2) / serial_port_pkg::rate_of(i));
  end

  // Pick calibrated table or raw divider
  always_comb begin
    if (auto_cal_in) begin
      if (baud_sel_in < 16'(serial_port_pkg::NUM_RATES)) begin
        next_bit_cycles = table_cycles[baud_sel_in[3:0]];
      end else begin
        next_bit_cycles = table_cycles[serial_port_pkg::NUM_RATES-1];
      end
    end else if (prescaler_in == 16'h0000) begin
      next_bit_cycles = 16'h0001;
    end else begin
      next_bit_cycles = prescaler_in;
    end
  end

  // Registered result
  always_ff @(posedge ref_clk_in) begin
    if (!rstn_in) begin
      bit_cycles_out <= serial_port_pkg::PRESC_RESET;
    end else begin
      bit_cycles_out <= next_bit_cycles;
    end
  end

endmodule : bit_rate_select

// ---- testbench/serial_port_checker.sv ----
// Pin assertions for serial_port.
// Bound onto every serial_port instance.
`timescale 1ns/1ps
module serial_port_checker (
  input wire logic       ref_clk_in, rstn_in, reg_wr_in, reg_rd_in,
  input wire logic [5:0] reg_addr_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic       rx_irq_out, tx_irq_out, txd_out, port_bit_five_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!rstn_in);
  // A write or a reset shortly before
  sequence s_cause; $past(reg_wr_in) || $past(reg_wr_in, 2) || !$past(rstn_in); endsequence
  property p_rst; disable iff (1'b0) !rstn_in |=> !rx_irq_out && !tx_irq_out && txd_out; endproperty
  a_rst: assert property (p_rst) else $error("reset");
  property p_idle; !reg_rd_in |=> reg_rdata_out == 8'h00; endproperty
  a_idle: assert property (p_idle) else $error("idle rd");
  property p_st7; reg_rd_in && reg_addr_in == 6'h2A |=> !reg_rdata_out[7]; endproperty
  a_st7: assert property (p_st7) else $error("st7");
  property p_unmap; reg_rd_in && reg_addr_in < 6'h29 |=> reg_rdata_out == 8'h00; endproperty
  a_unmap: assert property (p_unmap) else $error("unmap");
  property p_pin5; port_bit_five_out == 1'b0; endproperty
  a_pin5: assert property (p_pin5) else $error("pin5");
  property p_txend; $rose(tx_irq_out) |-> txd_out && $past(txd_out); endproperty
  a_txend: assert property (p_txend) else $error("tx end");
  property p_rxh; $fell(rx_irq_out) |-> s_cause; endproperty
  a_rxh: assert property (p_rxh) else $error("rx irq");
  property p_txh; $fell(tx_irq_out) |-> s_cause; endproperty
  a_txh: assert property (p_txh) else $error("tx irq");
endmodule : serial_port_checker
bind serial_port serial_port_checker chk (.ref_clk_in, .rstn_in, .reg_wr_in, .reg_rd_in,
  .reg_addr_in, .reg_rdata_out, .rx_irq_out, .tx_irq_out, .txd_out, .port_bit_five_out);

// ---- testbench/far_serial_port.sv ----
// Far chip serial port model.
// Bench clock; a bit lasts BIT clocks.
`timescale 1ns/1ps
module far_serial_port #(
  parameter int BIT = 8
) (
  input  wire logic ref_clk_in,
  input  wire logic line_in,
  output logic      line_out
);
  initial line_out = 1'b1;
  // Start, data LSB first, even parity, stop, idle bit
  task automatic send(input logic [7:0] d, input logic par_ok, input logic stop);
    logic [10:0] f;
    f = {stop, ^d ^ ~par_ok, d, 1'b0};
    for (int i = 0; i < 12; i++) begin
      repeat (BIT) @(posedge ref_clk_in) line_out <= i > 10 || f[i];
    end
  endtask : send
  // Sample data bits mid-bit
  task automatic get(output logic [7:0] d);
    @(negedge line_in);
    repeat (BIT + BIT / 2) @(posedge ref_clk_in);
    for (int i = 0; i < 8; i++) begin
      d[i] = line_in;
      repeat (BIT) @(posedge ref_clk_in);
    end
  endtask : get
endmodule : far_serial_port

// ---- testbench/serial_port_tb.sv ----
// Bench for serial_port with a far port model.
// Inputs change on rising edges of a 10 MHz clock.
`timescale 1ns/1ps
module serial_port_tb;
  logic       ref_clk_in, rstn_in, reg_wr_in, reg_rd_in, rxd_in;
  logic       rx_irq_out, tx_irq_out, txd_out, port_bit_five_out;
  logic [5:0] reg_addr_in;
  logic [7:0] reg_wdata_in, reg_rdata_out, got;
  int         num_errors, comparisons;
  serial_port dut (.ref_clk_in, .rstn_in, .reg_addr_in, .reg_wr_in, .reg_rd_in, .reg_wdata_in,
    .reg_rdata_out, .rx_irq_out, .tx_irq_out, .txd_out, .rxd_in, .port_bit_four_in(1'b0),
    .port_bit_five_out);
  far_serial_port far (.ref_clk_in, .line_in(txd_out), .line_out(rxd_in));
  initial begin
    ref_clk_in = 1'b0;
    forever #50 ref_clk_in = ~ref_clk_in;
  end
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] v);
    comparisons++;
    if (v !== e) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", n, e, v);
    end
  endtask : chk
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge ref_clk_in);
    {reg_addr_in, reg_wdata_in, reg_wr_in} <= {a, d, 1'b1};
    @(posedge ref_clk_in);
    reg_wr_in <= 1'b0;
  endtask : wr
  task automatic rd(input logic [5:0] a, input logic [7:0] m, input logic [7:0] e);
    @(posedge ref_clk_in);
    {reg_addr_in, reg_rd_in} <= {a, 1'b1};
    @(posedge ref_clk_in);
    reg_rd_in <= 1'b0;
    @(negedge ref_clk_in);
    chk($sformatf("reg %h", a), e, reg_rdata_out & m);
  endtask : rd
  task automatic t_tx;
    rd(6'h29, 8'hFF, 8'h00);
    rd(6'h2C, 8'hFF, 8'h56);
    rd(6'h2D, 8'hFF, 8'h00);
    rd(6'h2F, 8'hFF, 8'h00);
    rd(6'h28, 8'hFF, 8'h00);
    wr(6'h2C, 8'h08);
    wr(6'h29, 8'h01);
    fork
      far.get(got);
      wr(6'h2B, 8'hA5);
    join
    chk("tx byte", 8'hA5, got);
    repeat (40) if (!tx_irq_out) @(posedge ref_clk_in);
    chk("tx irq", 8'h01, {7'h00, tx_irq_out});
    rd(6'h2A, 8'h03, 8'h02);
    wr(6'h2A, 8'h1F);
  endtask : t_tx
  task automatic t_ovr;
    wr(6'h29, 8'h06);
    for (int i = 0; i < 9; i++) far.send(i[7:0], 1'b1, 1'b1);
    rd(6'h2A, 8'h08, 8'h08);
    for (int i = 0; i < 8; i++) rd(6'h2B, 8'hFF, i[7:0]);
    wr(6'h2A, 8'h1F);
  endtask : t_ovr
  task automatic t_rx;
    far.send(8'h3C, 1'b1, 1'b1);
    chk("rx irq", 8'h01, {7'h00, rx_irq_out});
    rd(6'h2A, 8'h3F, 8'h21);
    rd(6'h2B, 8'hFF, 8'h3C);
    far.send(8'h55, 1'b0, 1'b1);
    rd(6'h2A, 8'h14, 8'h10);
    far.send(8'h55, 1'b1, 1'b0);
    rd(6'h2A, 8'h04, 8'h04);
    wr(6'h2A, 8'h1F);
    wr(6'h29, 8'h0E);
    far.send(8'h55, 1'b0, 1'b1);
    rd(6'h2A, 8'h15, 8'h01);
  endtask : t_rx
  task automatic t_cal;
    int n;
    n = 0;
    wr(6'h29, 8'h10);
    wr(6'h2E, 8'h09);
    wr(6'h2B, 8'h01);
    repeat (9) if (txd_out) @(posedge ref_clk_in);
    while (!txd_out && n < 200) begin
      @(posedge ref_clk_in);
      n++;
    end
    chk("bit time", 8'h57, n[7:0]);
  endtask : t_cal
  task automatic conclude;
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : conclude
  initial begin
    {rstn_in, reg_wr_in, reg_rd_in, reg_addr_in, reg_wdata_in} = '0;
    repeat (3) @(posedge ref_clk_in);
    rstn_in <= 1'b1;
    t_tx();
    t_ovr();
    t_rx();
    t_cal();
    conclude();
  end
  initial begin
    #3000000;
    num_errors++;
    conclude();
  end
endmodule : serial_port_tb
